// file: rtl/sac_bus_if.sv
// Parallel microprocessor bus between converter and host
`timescale 1ns/100ps
`default_nettype none
interface sac_bus_if;
   logic       cs_n;             // Device select
   logic       rd_n;             // Read strobe
   logic       wr_n;             // Write strobe, starts conversion
   logic       byte_half_select; // High: status and upper bits
   logic [7:0] data_out;         // Device data drive value
   logic       data_oe;          // Device drives data bus
   logic [7:0] data;             // Resolved data bus level
   logic       busy_n;           // Idle indicator, low while converting

   // Undriven bus floats high
   assign data = data_oe ? data_out : sac_pkg::BUS_IDLE;

   modport dev  (input cs_n, rd_n, wr_n, byte_half_select, output data_out, data_oe, busy_n);
   modport host (output cs_n, rd_n, wr_n, byte_half_select, input data, busy_n);
endinterface
`default_nettype wire

// file: rtl/sac_device.sv
// Conversion control logic of the successive-approximation converter
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sac_device #(
   parameter int AZ_CYC  = sac_pkg::AZ_CYCLES,  // Autozero length in cycles, internal clock mode only
   parameter int PER_CYC = sac_pkg::CONV_PERIOD // Internal conversion period
) (
   sac_bus_if.dev           BUS,          // Microprocessor bus pins
   input  wire logic        CLK_SYS,      // System clock
   input  wire logic        RESET,        // Synchronous reset, active high
   input  wire logic        EXT_CLK_MODE, // High: use EXT_CLK for bit timing
   input  wire logic        EXT_CLK,      // External conversion clock
   input  wire logic        COMP_KEEP,    // Comparator: trial bit stays set
   output logic             AUTOZERO,     // High whenever not converting bits: idle, start and autozero
   output logic [11:0]      TRIAL         // Trial code for the DAC
);

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_AZ, ST_CONV} sac_state_t;

   sac_state_t                         state;
   sac_state_t                         next_state;
   logic [sac_pkg::RES_BITS-1:0]       sar;
   logic [sac_pkg::RES_BITS-1:0]       next_sar;
   logic [sac_pkg::IDX_W-1:0]          idx;
   logic [sac_pkg::IDX_W-1:0]          next_idx;
   logic [sac_pkg::CNT_W-1:0]          cnt;
   logic [sac_pkg::CNT_W-1:0]          next_cnt;
   logic                               busy;
   logic                               next_busy;
   logic                               ext_prev;
   logic [sac_pkg::BUS_BITS-1:0]       rdata;
   logic [sac_pkg::BUS_BITS-1:0]       next_rdata;
   logic                               write_req;
   logic                               ext_fall;
   logic                               per_end;
   logic                               az_end;

   // Trial value holding only the given bit
   function automatic logic [sac_pkg::RES_BITS-1:0] bit_mask(input logic [sac_pkg::IDX_W-1:0] i);
      bit_mask = sac_pkg::RES_BITS'(1) << i;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer

   always_comb begin
      write_req = !BUS.cs_n && !BUS.wr_n;
      ext_fall  = ext_prev && !EXT_CLK;
      per_end   = (cnt == sac_pkg::CNT_W'(PER_CYC - 1));
      az_end    = (cnt == sac_pkg::CNT_W'(AZ_CYC - 1));
      next_state = state;
      next_sar   = sar;
      next_idx   = idx;
      next_cnt   = cnt;
      next_busy  = busy;
      case (state)
         ST_IDLE: begin
         end
         ST_START: begin
            next_state = ST_AZ;
            next_cnt   = '0;
         end
         ST_AZ: begin
            if (EXT_CLK_MODE) begin
               if (ext_fall) begin
                  next_state = ST_CONV;
               end
            end else begin
               next_cnt = cnt + sac_pkg::CNT_W'(1);
               if (az_end) begin
                  next_state = ST_CONV;
                  next_cnt   = '0;
               end
            end
         end
         ST_CONV: begin
            next_cnt = per_end ? '0 : cnt + sac_pkg::CNT_W'(1);
            if (EXT_CLK_MODE ? ext_fall : per_end) begin
               if (!COMP_KEEP) begin
                  next_sar = sar & ~bit_mask(idx);
               end
               if (idx != '0) begin
                  next_idx = idx - sac_pkg::IDX_W'(1);
                  next_sar = next_sar | bit_mask(next_idx);
               end else begin
                  // Busy ends on the same edge that stores the last bit
                  next_state = ST_IDLE;
                  next_busy  = 1'b0;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (write_req) begin
         next_state = ST_START;
         next_idx   = sac_pkg::IDX_W'(sac_pkg::RES_BITS - 1);
         next_sar   = bit_mask(sac_pkg::IDX_W'(sac_pkg::RES_BITS - 1));
         next_cnt   = '0;
         next_busy  = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state    <= ST_IDLE;
         sar      <= '0;
         idx      <= '0;
         cnt      <= '0;
         busy     <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         state    <= next_state;
         sar      <= next_sar;
         idx      <= next_idx;
         cnt      <= next_cnt;
         busy     <= next_busy;
         ext_prev <= EXT_CLK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   always_comb begin
      if (BUS.byte_half_select) begin
         // Status bit is the top line
         next_rdata = {busy, {sac_pkg::HI_PAD_BITS{1'b0}},
                       sar[sac_pkg::RES_BITS-1 -: sac_pkg::HI_DATA_BITS]};
      end else begin
         next_rdata = sar[sac_pkg::BUS_BITS-1:0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign BUS.data_out = rdata;
   // Drive only during select and read
   assign BUS.data_oe  = !BUS.cs_n && !BUS.rd_n;
   assign BUS.busy_n   = !busy;
   assign AUTOZERO     = (state != ST_CONV);
   assign TRIAL        = sar;

endmodule // sac_device
`default_nettype wire

// file: rtl/sac_host.sv
// Host controller that starts conversions and fetches results
`timescale 1ns/100ps
`default_nettype none
module sac_host #(
   parameter int WR_INT = sac_pkg::WR_INT_CYCLES, // Write pulse, internal clock
   parameter int WR_EXT = sac_pkg::AZ_CYCLES,     // Write pulse, external clock
   parameter int RD_CYC = sac_pkg::RD_CYCLES      // Cycles per byte read
) (
   sac_bus_if.host                    BUS,     // Bus to the converter
   input  wire logic                  CLK_SYS, // System clock
   input  wire logic                  RESET,   // Synchronous reset, active high
   input  wire logic [3:0]            ADDR,    // Register address
   input  wire logic [15:0]           WDATA,   // Write data
   input  wire logic                  WR_STB,  // Write strobe
   input  wire logic                  RD_STB,  // Read strobe
   output logic      [15:0]           RDATA    // Read data, cycle after strobe
);

   typedef enum logic [2:0] {HS_IDLE, HS_WRITE, HS_WAIT, HS_RD_LO, HS_RD_HI} sac_hstate_t;

   sac_hstate_t                  state;
   sac_hstate_t                  next_state;
   logic [sac_pkg::CNT_W-1:0]    cnt;
   logic [sac_pkg::CNT_W-1:0]    next_cnt;
   logic                         ext_mode;
   logic                         next_ext_mode;
   logic                         done;
   logic                         next_done;
   logic [sac_pkg::RES_BITS-1:0] result;
   logic [sac_pkg::RES_BITS-1:0] next_result;
   logic [sac_pkg::DATA_W-1:0]   next_rdata;
   logic                         cs_n;
   logic                         rd_n;
   logic                         wr_n;
   logic                         half_sel;
   logic                         wr_last;
   logic                         rd_last;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and registers

   always_comb begin
      wr_last = (cnt == sac_pkg::CNT_W'((ext_mode ? WR_EXT : WR_INT) - 1));
      rd_last = (cnt == sac_pkg::CNT_W'(RD_CYC - 1));
      next_state    = state;
      next_cnt      = cnt + sac_pkg::CNT_W'(1);
      next_ext_mode = ext_mode;
      next_done     = done;
      next_result   = result;
      next_rdata    = '0;
      case (state)
         HS_IDLE: next_cnt = '0;
         HS_WRITE: begin
            if (wr_last) begin
               next_state = HS_WAIT;
               next_cnt   = '0;
            end
         end
         HS_WAIT: begin
            next_cnt = '0;
            if (BUS.busy_n) begin
               next_state = HS_RD_LO;
            end
         end
         HS_RD_LO: begin
            if (rd_last) begin
               next_result[sac_pkg::BUS_BITS-1:0] = BUS.data;
               next_state = HS_RD_HI;
               next_cnt   = '0;
            end
         end
         HS_RD_HI: begin
            if (rd_last) begin
               next_result[sac_pkg::RES_BITS-1:sac_pkg::BUS_BITS] =
                  BUS.data[sac_pkg::HI_DATA_BITS-1:0];
               next_state = HS_IDLE;
               next_cnt   = '0;
            end
         end
         default: next_state = HS_IDLE;
      endcase
      if (WR_STB && ADDR == sac_pkg::REG_CTRL) begin
         next_ext_mode = WDATA[sac_pkg::CTRL_EXT];
         if (WDATA[sac_pkg::CTRL_START]) begin
            next_state = HS_WRITE;
            next_cnt   = '0;
            next_done  = 1'b0;
         end
      end
      if (WR_STB && ADDR == sac_pkg::REG_STATUS && WDATA[sac_pkg::STAT_DONE]) begin
         next_done = 1'b0;
      end
      // Completion wins over a clear in the same cycle
      if (state == HS_RD_HI && rd_last) begin
         next_done = 1'b1;
      end
      if (RD_STB) begin
         case (ADDR)
            sac_pkg::REG_CTRL:   next_rdata = sac_pkg::DATA_W'({ext_mode, 1'b0});
            sac_pkg::REG_STATUS: next_rdata = sac_pkg::DATA_W'({done, state != HS_IDLE});
            sac_pkg::REG_RESULT: next_rdata = sac_pkg::DATA_W'(result);
            default:             next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state    <= HS_IDLE;
         cnt      <= '0;
         ext_mode <= 1'b0;
         done     <= 1'b0;
         result   <= '0;
         RDATA    <= '0;
         cs_n     <= 1'b1;
         rd_n     <= 1'b1;
         wr_n     <= 1'b1;
         half_sel <= 1'b0;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         ext_mode <= next_ext_mode;
         done     <= next_done;
         result   <= next_result;
         RDATA    <= next_rdata;
         cs_n     <= !(next_state == HS_WRITE || next_state == HS_RD_LO || next_state == HS_RD_HI);
         wr_n     <= (next_state != HS_WRITE);
         rd_n     <= !(next_state == HS_RD_LO || next_state == HS_RD_HI);
         half_sel <= (next_state == HS_RD_HI);
      end
   end

   assign BUS.cs_n             = cs_n;
   assign BUS.rd_n             = rd_n;
   assign BUS.wr_n             = wr_n;
   assign BUS.byte_half_select = half_sel;

endmodule // sac_host
`default_nettype wire

// file: rtl/sac_pkg.sv
// Shared constants of the converter control block and its host controller
package sac_pkg;
   localparam int RES_BITS      = 12;
   localparam int BUS_BITS      = 8;
   localparam int HI_DATA_BITS  = 4;
   localparam int HI_PAD_BITS   = 3;
   localparam int SYS_CLK_HZ    = 125000000;
   localparam int SYS_PERIOD_NS = 8;
   // Autozero least time and its cycle count, rounded up
   localparam int AZ_TIME_NS    = 10000;
   localparam int AZ_CYCLES     = (AZ_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   // Conversion clock of 140kHz, period rounded down
   localparam int CONV_CLK_HZ   = 140000;
   localparam int CONV_PERIOD   = SYS_CLK_HZ / CONV_CLK_HZ;
   localparam int CONV_TIME_US  = 100;
   localparam int CNT_W         = 16;
   localparam int IDX_W         = 4;
   // Host timing
   localparam int WR_INT_CYCLES = 2;
   localparam int RD_CYCLES     = 3;
   // Host register map
   localparam int ADDR_W        = 4;
   localparam int DATA_W        = 16;
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_RESULT = 4'h2;
   localparam int CTRL_START    = 0;
   localparam int CTRL_EXT      = 1;
   localparam int STAT_ACTIVE   = 0;
   localparam int STAT_DONE     = 1;
   localparam logic [7:0] BUS_IDLE = 8'hFF;
endpackage

// file: testbench/sac_conv_sva.sv
// Concurrent checks on the bus joining the converter and its host
`timescale 1ns/100ps
`default_nettype none
module sac_conv_sva #(
   parameter int AZ_CYC  = sac_pkg::AZ_CYCLES,         // Autozero cycles
   parameter int PER_CYC = sac_pkg::CONV_PERIOD,       // Bit period cycles
   parameter int MAX_CYC = 2 * (AZ_CYC + 12 * PER_CYC) // Longest busy span
) (
   input wire logic       CLK_SYS,          // System clock
   input wire logic       RESET,            // Sync reset
   input wire logic       cs_n,             // Select
   input wire logic       rd_n,             // Read strobe
   input wire logic       wr_n,             // Write strobe
   input wire logic       byte_half_select, // Byte half
   input wire logic [7:0] data_out,         // Device drive value
   input wire logic       data_oe,          // Device drives bus
   input wire logic [7:0] data,             // Resolved bus
   input wire logic       busy_n            // Idle indicator
);
   localparam int MIN_CYC = AZ_CYC + 12 * PER_CYC - 1;
   logic [15:0] busy_cnt;
   logic [15:0] next_busy_cnt;
   ////////////////////////////////////////////////////////////
   // Busy span since the last accepted write
   always_comb begin
      next_busy_cnt = busy_cnt;
      if (!cs_n && !wr_n) begin
         next_busy_cnt = 16'h0000;
      end else if (!busy_n) begin
         next_busy_cnt = busy_cnt + 16'h0001;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         busy_cnt <= 16'h0000;
      end else begin
         busy_cnt <= next_busy_cnt;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   sequence s_start;
      !cs_n && !wr_n;
   endsequence
   sequence s_done;
      $rose(busy_n);
   endsequence
   chk_bus_drive: assert property (data_oe == (!cs_n && !rd_n))
      else $error("bus driven outside a read");
   chk_start_busy: assert property (s_start |=> !busy_n)
      else $error("write did not start a conversion");
   chk_conv_min: assert property (s_done |-> busy_cnt >= 16'(MIN_CYC))
      else $error("conversion ended too early");
   chk_conv_max: assert property (busy_cnt <= 16'(MAX_CYC))
      else $error("conversion ran too long");
   chk_high_byte: assert property (data_oe && $past(data_oe) && $past(byte_half_select) && $stable(busy_n)
      |-> data[7:4] == {!busy_n, 3'b000})
      else $error("high byte layout wrong");
   chk_pad_zero: assert property ($past(byte_half_select) |-> data_out[6:4] == 3'b000)
      else $error("high byte pad lines not zero");
   chk_sel_thru_wr: assert property (!wr_n |-> !cs_n)
      else $error("select dropped during write");
   chk_wr_width: assert property ($fell(wr_n) |-> !wr_n ##1 !wr_n)
      else $error("write pulse too short");
   chk_restart_hold: assert property ((s_start and !busy_n) |=> !busy_n [*3])
      else $error("restart left the busy state");
   chk_read_done: assert property (!rd_n |-> busy_n)
      else $error("read during conversion");
endmodule // sac_conv_sva
`default_nettype wire

// file: testbench/sar_adc_conversion_control_test.sv
// Self-checking bench of the converter control and its host
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_control_test;
   localparam int AZ  = 20;
   localparam int PER = 8;
   logic        CLK_SYS;
   logic        RESET;
   logic [3:0]  ADDR;
   logic [15:0] WDATA;
   logic        WR_STB;
   logic        RD_STB;
   logic [15:0] RDATA;
   logic        EXT_CLK_MODE;
   logic        EXT_CLK = 1'b0;
   logic [3:0]  ext_div = 4'h0;
   logic        AUTOZERO;
   logic [11:0] TRIAL;
   logic [11:0] target;
   logic [15:0] rd_val;
   int          error_cnt;
   int          checks_done;
   logic [11:0] codes [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
   // Comparator: keep the trial bit while it does not exceed the input
   wire logic comp_keep = (TRIAL <= target);
   sac_bus_if bus ();
   sac_device #(.AZ_CYC(AZ), .PER_CYC(PER)) i_sac_device (
      .BUS(bus), .CLK_SYS(CLK_SYS), .RESET(RESET), .EXT_CLK_MODE(EXT_CLK_MODE),
      .EXT_CLK(EXT_CLK), .COMP_KEEP(comp_keep), .AUTOZERO(AUTOZERO), .TRIAL(TRIAL));
   sac_host #(.WR_INT(2), .WR_EXT(AZ), .RD_CYC(3)) i_sac_host (
      .BUS(bus), .CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA));
   sac_conv_sva #(.AZ_CYC(AZ), .PER_CYC(PER), .MAX_CYC(200)) i_sac_conv_sva (
      .CLK_SYS(CLK_SYS), .RESET(RESET), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
      .byte_half_select(bus.byte_half_select), .data_out(bus.data_out),
      .data_oe(bus.data_oe), .data(bus.data), .busy_n(bus.busy_n));
   ////////////////////////////////////////////////////////////
   initial begin
      CLK_SYS = 1'b0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      ext_div <= (ext_div == 4'h4) ? 4'h0 : ext_div + 4'h1;
      if (ext_div == 4'h4) EXT_CLK <= ~EXT_CLK;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK_SYS);
      ADDR   <= a;
      WDATA  <= d;
      WR_STB <= 1'b1;
      @(posedge CLK_SYS);
      WR_STB <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge CLK_SYS);
      ADDR   <= a;
      RD_STB <= 1'b1;
      @(posedge CLK_SYS);
      RD_STB <= 1'b0;
      #1;
      rd_val = RDATA;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 300; i++) begin
         rd_reg(sac_pkg::REG_STATUS);
         if (rd_val[1] === 1'b1) return;
      end
      check("conversion done", rd_val, 16'h0002);
      end_sim();
   endtask
   task automatic start(input logic ext, input logic [11:0] code);
      @(posedge CLK_SYS);
      target       <= code;
      EXT_CLK_MODE <= ext;
      wr_reg(sac_pkg::REG_CTRL, {14'h0000, ext, 1'b1});
   endtask
   task automatic finish_conv(input logic [11:0] code);
      wait_done();
      check("status done", rd_val, 16'h0002);
      rd_reg(sac_pkg::REG_RESULT);
      check("result", rd_val, {4'h0, code});
      check("idle out", {15'h0000, bus.busy_n}, 16'h0001);
      wr_reg(sac_pkg::REG_STATUS, 16'h0002);
      rd_reg(sac_pkg::REG_STATUS);
      check("done cleared", rd_val, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      RESET        = 1'b1;
      ADDR         = 4'h0;
      WDATA        = 16'h0000;
      WR_STB       = 1'b0;
      RD_STB       = 1'b0;
      EXT_CLK_MODE = 1'b0;
      target       = 12'h000;
      error_cnt    = 0;
      checks_done  = 0;
      repeat (3) @(posedge CLK_SYS);
      RESET <= 1'b0;
      #1;
      check("idle autozero", {15'h0000, AUTOZERO}, 16'h0001);
      check("idle out", {15'h0000, bus.busy_n}, 16'h0001);
      rd_reg(sac_pkg::REG_STATUS);
      check("status reset", rd_val, 16'h0000);
      rd_reg(4'h7);
      check("unmapped", rd_val, 16'h0000);
      $display("test reset done");
      foreach (codes[i]) begin
         start(1'b0, codes[i]);
         finish_conv(codes[i]);
      end
      $display("test internal clock done");
      start(1'b1, 12'h3C5);
      finish_conv(12'h3C5);
      rd_reg(sac_pkg::REG_CTRL);
      check("ext mode", rd_val, 16'h0002);
      start(1'b1, 12'h001);
      finish_conv(12'h001);
      $display("test external clock done");
      start(1'b0, 12'h123);
      repeat (40) @(posedge CLK_SYS);
      #1;
      check("busy mid", {15'h0000, bus.busy_n}, 16'h0000);
      check("deciding", {15'h0000, AUTOZERO}, 16'h0000);
      check("trial mid", {4'h0, TRIAL}, 16'h0200);
      start(1'b0, 12'h9AB);
      repeat (4) @(posedge CLK_SYS);
      #1;
      check("restart code", {4'h0, TRIAL}, 16'h0800);
      check("restart autozero", {15'h0000, AUTOZERO}, 16'h0001);
      finish_conv(12'h9AB);
      $display("test restart done");
      end_sim();
   end
endmodule // sar_adc_conversion_control_test
`default_nettype wire
